//--- rtl/tcc_pkg.sv
package tcc_pkg;

  // ----------------------------------------------------------------
  // Bus and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CH_N = 2;
  localparam int NC_DEPTH = 4;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_IEN = 5'h08;
  localparam logic [4:0] OFF_FORCE = 5'h0c;
  localparam logic [4:0] OFF_CAPT = 5'h10;
  localparam logic [4:0] OFF_CMPA = 5'h14;
  localparam logic [4:0] OFF_CMPB = 5'h18;
  localparam logic [4:0] OFF_CNT = 5'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_ACSEL = 0;
  localparam int CTL_NCEN = 1;
  localparam int CTL_EDGE = 2;
  localparam int CTL_WGM_LO = 3;
  localparam int CTL_COM_LO = 8;
  localparam int ST_CAP = 0;
  localparam int ST_CMP_LO = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [2:0] IEN_RST = 3'h0;
  localparam logic [15:0] OCR_RST = 16'h0000;
  localparam logic [15:0] ICR_RST = 16'h0000;
  localparam logic OC_RST = 1'b0;

  // ----------------------------------------------------------------
  // Modes and fixed values
  // ----------------------------------------------------------------
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_CTC_I = 4'hc;
  localparam logic [3:0] WGM_RSVD = 4'hd;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8B = 16'h00ff;
  localparam logic [15:0] TOP_9B = 16'h01ff;
  localparam logic [15:0] TOP_10B = 16'h03ff;

  typedef enum logic [1:0] {
    TCC_COM_OFF,
    TCC_COM_TOGGLE,
    TCC_COM_CLEAR,
    TCC_COM_SET
  } tcc_com_t;

  typedef struct packed {
    logic [15:0] value;
    logic top;
    logic bottom;
    logic tick;
    logic up;
  } tcc_cnt_t;

  typedef struct packed {
    logic o;
    logic oe;
  } tcc_pin_t;

  function automatic logic tcc_is_pwm(input logic [3:0] m);
    return !(m == WGM_NORMAL || m == WGM_CTC_A || m == WGM_CTC_I ||
             m == WGM_RSVD);
  endfunction

  function automatic logic tcc_icr_top(input logic [3:0] m);
    return m == 4'h8 || m == 4'ha || m == 4'hc || m == 4'he;
  endfunction

  function automatic logic tcc_ocra_top(input logic [3:0] m);
    return m == 4'h4 || m == 4'h9 || m == 4'hb || m == 4'hf;
  endfunction

  function automatic logic tcc_fast(input logic [3:0] m);
    return m == 4'h5 || m == 4'h6 || m == 4'h7 || m == 4'he ||
           m == 4'hf;
  endfunction

  function automatic logic tcc_upd_bottom(input logic [3:0] m);
    return m == 4'h8 || m == 4'h9;
  endfunction

endpackage

//--- rtl/tcc_filter.sv
`timescale 1ns/100ps
module tcc_filter
  import tcc_pkg::*;
#(
  parameter int DEPTH = NC_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  input wire logic hold,
  input wire logic en,
  output logic dout
);

  logic [DEPTH-1:0] sh_r;
  logic dout_r;
  logic all_one;
  logic all_zero;
  logic dout_nxt;

  // ----------------------------------------------------------------
  // Sample pipeline
  // ----------------------------------------------------------------
  assign all_one = &sh_r;
  assign all_zero = ~|sh_r;
  assign dout_nxt = !en ? din :
                    all_one ? 1'b1 :
                    all_zero ? 1'b0 : dout_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_r <= '0;
      dout_r <= 1'b0;
    end else if (!hold) begin
      sh_r <= {sh_r[DEPTH-2:0], din};
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;

endmodule

//--- rtl/tcc_unit.sv
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module tcc_unit
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire tcc_cnt_t cnt,
  output logic cnt_wr,
  output logic [15:0] cnt_wdata,
  output logic [15:0] top_value,
  output logic top_match,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic [CH_N-1:0] port_data,
  input wire logic [CH_N-1:0] compare_pin_direction,
  output tcc_pin_t [CH_N-1:0] compare_pin,
  output logic [2:0] irq_req,
  input wire logic [2:0] irq_ack
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [11:0] ctrl_r;
  logic [2:0] ien_r;
  logic [2:0] flag_r;
  logic [15:0] icr_r;
  logic [7:0] temp_r;
  logic [15:0] ocr_r [CH_N];
  logic [15:0] buf_r [CH_N];
  logic [CH_N-1:0] oc_r;
  logic blk_r;
  logic ack_r;
  logic [DATA_W-1:0] rdata_r;
  logic cnt_wr_r;
  logic [15:0] cnt_wdata_r;
  logic cap_lvl_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ack_r;
  wire hit_ctrl = avs_address == OFF_CTRL;
  wire hit_stat = avs_address == OFF_STAT;
  wire hit_ien = avs_address == OFF_IEN;
  wire hit_force = avs_address == OFF_FORCE;
  wire hit_capt = avs_address == OFF_CAPT;
  wire hit_cnt = avs_address == OFF_CNT;
  wire [CH_N-1:0] hit_cmp = {avs_address == OFF_CMPB,
                             avs_address == OFF_CMPA};
  wire [3:0] wgm = ctrl_r[CTL_WGM_LO +: 4];
  wire pwm = tcc_is_pwm(wgm);
  wire icr_top = tcc_icr_top(wgm);
  wire ocra_top = tcc_ocra_top(wgm);
  wire fast = tcc_fast(wgm);
  wire upd_ev = cnt.tick &
                (tcc_upd_bottom(wgm) ? cnt.bottom : cnt.top);

  assign avs_waitrequest = req & ~ack_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // reads buffer or register
  wire [15:0] cmp_view0 = pwm ? buf_r[0] : ocr_r[0];
  wire [15:0] cmp_view1 = pwm ? buf_r[1] : ocr_r[1];
  wire [DATA_W-1:0] rd_mux =
    hit_ctrl ? {20'h00000, ctrl_r} :
    hit_stat ? {29'h00000000, flag_r} :
    hit_ien ? {29'h00000000, ien_r} :
    hit_capt ? {16'h0000, icr_r} :
    hit_cmp[0] ? {16'h0000, cmp_view0} :
    hit_cmp[1] ? {16'h0000, cmp_view1} :
    hit_cnt ? {16'h0000, cnt.value} : 32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h00000000;
    end else if (avs_read & ~ack_r) begin
      rdata_r <= rd_mux;
    end
  end

  assign avs_readdata = rdata_r;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // mode change immediate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      ien_r <= IEN_RST;
    end else if (wr_go) begin
      if (hit_ctrl && avs_byteenable[0]) begin
        ctrl_r[7:0] <= avs_writedata[7:0];
      end
      if (hit_ctrl && avs_byteenable[1]) begin
        ctrl_r[11:8] <= avs_writedata[11:8];
      end
      if (hit_ien && avs_byteenable[0]) begin
        ien_r <= avs_writedata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared high-byte latch and counter write
  // ----------------------------------------------------------------
  wire cmp_hi_wr = wr_go & (|hit_cmp) & avs_byteenable[1];
  wire cmp_lo_wr = wr_go & (|hit_cmp) & avs_byteenable[0];
  wire [15:0] cmp_word = {cmp_hi_wr ? avs_writedata[15:8] : temp_r,
                          avs_writedata[7:0]};
  wire cnt_go = wr_go & hit_cnt & (&avs_byteenable[1:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_r <= 8'h00;
    end else if (cmp_hi_wr) begin
      temp_r <= avs_writedata[15:8];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_wr_r <= 1'b0;
      cnt_wdata_r <= 16'h0000;
    end else begin
      cnt_wr_r <= cnt_go;
      cnt_wdata_r <= cnt_go ? avs_writedata[15:0] : cnt_wdata_r;
    end
  end

  assign cnt_wr = cnt_wr_r;
  assign cnt_wdata = cnt_wdata_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blk_r <= 1'b0;
    end else if (cnt_go) begin
      blk_r <= 1'b1;
    end else if (cnt.tick) begin
      blk_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  // trigger source select
  wire cap_src = ctrl_r[CTL_ACSEL] ? comparator_output : capture_pin;
  wire cap_filt;

  tcc_filter #(
    .DEPTH(NC_DEPTH)
  ) u_filter (
    .clk(clk),
    .rst(rst),
    .din(cap_src),
    .hold(icr_top),
    .en(ctrl_r[CTL_NCEN]),
    .dout(cap_filt)
  );

  wire cap_ev = !icr_top && (cap_filt != cap_lvl_r) &&
                (cap_filt == ctrl_r[CTL_EDGE]);
  wire capt_wr = wr_go & hit_capt & icr_top & avs_byteenable[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_lvl_r <= 1'b0;
      icr_r <= ICR_RST;
    end else begin
      cap_lvl_r <= cap_filt;
      if (cap_ev) begin
        icr_r <= cnt.value;
      end else if (capt_wr) begin
        icr_r <= {avs_byteenable[1] ? avs_writedata[15:8] : temp_r,
                  avs_writedata[7:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // TOP supply
  // ----------------------------------------------------------------
  // channel A as TOP
  assign top_value = ocra_top ? ocr_r[0] :
                     icr_top ? icr_r :
                     (wgm[1:0] == 2'h1) ? TOP_8B :
                     (wgm[1:0] == 2'h2) ? TOP_9B :
                     (wgm[1:0] == 2'h3) ? TOP_10B : CNT_MAX;
  // blocked TOP match lets counter run on
  assign top_match = (cnt.value == top_value) & ~blk_r;

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  wire [CH_N-1:0] match;
  wire [CH_N-1:0] flag_set;
  wire [CH_N-1:0] force_go;

  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      wire [1:0] com = ctrl_r[CTL_COM_LO + 2*g +: 2];
      logic oc_nxt;
      assign match[g] = cnt.value == ocr_r[g];
      assign flag_set[g] = cnt.tick & match[g] & ~blk_r;
      assign force_go[g] = wr_go & hit_force & avs_byteenable[0] &
                           avs_writedata[g] & ~pwm;

      always_comb begin
        oc_nxt = oc_r[g];
        if (!pwm) begin
          case (tcc_com_t'(com))
            TCC_COM_TOGGLE: oc_nxt = ~oc_r[g];
            TCC_COM_CLEAR: oc_nxt = 1'b0;
            TCC_COM_SET: oc_nxt = 1'b1;
            default: oc_nxt = oc_r[g];
          endcase
        end else if (com[1]) begin
          if (flag_set[g]) begin
            oc_nxt = fast ? com[0] : (cnt.up ? com[0] : ~com[0]);
          end else if (fast) begin
            oc_nxt = ~com[0];
          end
        end
      end

      wire oc_ev = force_go[g] | flag_set[g] |
                   (pwm & fast & cnt.tick & cnt.bottom);

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          oc_r[g] <= OC_RST;
        end else if (oc_ev) begin
          oc_r[g] <= oc_nxt;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          buf_r[g] <= OCR_RST;
          ocr_r[g] <= OCR_RST;
        end else begin
          if (cmp_lo_wr && hit_cmp[g]) begin
            buf_r[g] <= cmp_word;
          end
          if (cmp_lo_wr && hit_cmp[g] && !pwm) begin
            ocr_r[g] <= cmp_word;
          end else if (pwm && upd_ev) begin
            ocr_r[g] <= buf_r[g];
          end
        end
      end

      assign compare_pin[g].o = (com != 2'b00) ? oc_r[g] : port_data[g];
      assign compare_pin[g].oe = compare_pin_direction[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  wire [2:0] flag_hw = {flag_set, cap_ev};
  wire [2:0] flag_w1c = (wr_go & hit_stat & avs_byteenable[0]) ?
                        avs_writedata[2:0] : 3'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= 3'h0;
    end else begin
      flag_r <= flag_hw | (flag_r & ~flag_w1c & ~irq_ack);
    end
  end

  assign irq_req = flag_r & ien_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_lo_wr_a;
    cmp_lo_wr && hit_cmp[0];
  endsequence

  property p_flag_next_tick;
    cnt.tick && match[0] && !blk_r |=> flag_r[ST_CMP_LO];
  endproperty
  a_flag_next_tick: assert property (p_flag_next_tick)
    else $error("match did not set compare flag");

  property p_block;
    cnt.tick && blk_r && !flag_r[ST_CMP_LO] |=> !flag_r[ST_CMP_LO];
  endproperty
  a_block: assert property (p_block)
    else $error("blocked match set a flag");

  property p_capture;
    cap_ev |=> icr_r == $past(cnt.value) && flag_r[ST_CAP];
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not load counter value");

  property p_direct_write;
    s_lo_wr_a ##0 !pwm |=> ocr_r[0] == $past(cmp_word);
  endproperty
  a_direct_write: assert property (p_direct_write)
    else $error("compare word not moved in one cycle");

  property p_buffered;
    s_lo_wr_a ##0 pwm ##0 !upd_ev |=> $stable(ocr_r[0]);
  endproperty
  a_buffered: assert property (p_buffered)
    else $error("buffered compare changed before update");

  property p_force;
    force_go[0] && !flag_set[0] && ctrl_r[9:8] == 2'b01 |=>
      oc_r[0] != $past(oc_r[0]) && !$rose(flag_r[ST_CMP_LO]);
  endproperty
  a_force: assert property (p_force)
    else $error("force did not toggle output");

  property p_com_zero;
    ctrl_r[9:8] == 2'b00 && !pwm |=> $stable(oc_r[0]);
  endproperty
  a_com_zero: assert property (p_com_zero)
    else $error("output changed with mode zero");

  property p_pin;
    ctrl_r[9:8] != 2'b00 |-> compare_pin[0].o == oc_r[0];
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin not overridden by compare output");

  property p_icr_gate;
    icr_top [*2] |-> !cap_ev;
  endproperty
  a_icr_gate: assert property (p_icr_gate)
    else $error("capture in capture-TOP mode");

  property p_ack_clear;
    irq_ack[1] && !flag_set[0] |=> !flag_r[ST_CMP_LO];
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("service did not clear compare flag");

endmodule

//--- verification/tcc_cnt_model.sv
`timescale 1ns/100ps
module tcc_cnt_model
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic cnt_wr,
  input wire logic [15:0] cnt_wdata,
  input wire logic [15:0] top_value,
  output tcc_cnt_t cnt
);
  // ----------------------------------------------------------------
  // Counter unit stand-in
  // ----------------------------------------------------------------
  logic [15:0] value_r;
  assign cnt.value = value_r;
  assign cnt.top = value_r == top_value;
  assign cnt.bottom = value_r == 16'h0000;
  assign cnt.tick = run;
  assign cnt.up = 1'h1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_r <= 16'h0000;
    end else if (cnt_wr) begin
      value_r <= cnt_wdata;
    end else if (run) begin
      value_r <= cnt.top ? 16'h0000 : value_r + 16'h0001;
    end
  end
endmodule

//--- verification/test_timer16_capture_compare_unit.sv
`timescale 1ns/100ps
module test_timer16_capture_compare_unit;
  import tcc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  tcc_cnt_t cnt;
  logic cnt_wr;
  logic [15:0] cnt_wdata;
  logic [15:0] top_value;
  logic top_match;
  logic capture_pin = 1'h0;
  logic comparator_output = 1'h0;
  logic [CH_N-1:0] port_data = 2'h3;
  logic [CH_N-1:0] compare_pin_direction = 2'h1;
  tcc_pin_t [CH_N-1:0] compare_pin;
  logic [2:0] irq_req;
  logic [2:0] irq_ack = 3'h0;
  logic run = 1'h0;
  logic [31:0] rd;
  int fails = 0;
  int checks_done = 0;
  int n0;
  int n1;

  always #12.5 clk = ~clk;

  tcc_unit dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cnt(cnt), .cnt_wr(cnt_wr), .cnt_wdata(cnt_wdata),
    .top_value(top_value), .top_match(top_match),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .port_data(port_data), .compare_pin_direction(compare_pin_direction),
    .compare_pin(compare_pin), .irq_req(irq_req), .irq_ack(irq_ack));

  tcc_cnt_model model_u (.clk(clk), .rst(rst), .run(run),
    .cnt_wr(cnt_wr), .cnt_wdata(cnt_wdata), .top_value(top_value),
    .cnt(cnt));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task conclude;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask

  task bus(input logic we, input logic [4:0] a, input logic [31:0] d,
           input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 16);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (avs_waitrequest !== 1'h0) begin
      fails++;
      conclude();
    end
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'h1, a, d, be);
  endtask

  task rdchk(input logic [4:0] a, input logic [31:0] exp, input string s);
    bus(1'h0, a, 32'h0, 4'hf);
    chk(rd, exp, s);
  endtask

  task cw(input logic [15:0] v);
    wr(OFF_CNT, {16'h0000, v}, 4'h3);
    repeat (2) @(posedge clk);
  endtask

  task tk(input int n);
    @(posedge clk);
    run <= 1'h1;
    repeat (n) @(posedge clk);
    run <= 1'h0;
    @(posedge clk);
  endtask

  task lat(input logic use_cmp, output int n);
    @(posedge clk);
    if (use_cmp) begin
      comparator_output <= 1'h1;
    end else begin
      capture_pin <= 1'h1;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq_req[0] !== 1'h1 && n < 20);
    capture_pin <= 1'h0;
    comparator_output <= 1'h0;
    if (irq_req[0] !== 1'h1) begin
      fails++;
      conclude();
    end
    repeat (10) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rdchk(OFF_CTRL, 32'h0, "ctrl reset");
    rdchk(OFF_STAT, 32'h0, "status reset");
    rdchk(OFF_IEN, 32'h0, "enable reset");
    rdchk(OFF_CAPT, 32'h0, "capture reset");
    rdchk(OFF_CMPA, 32'h0, "compare a reset");
    rdchk(OFF_CMPB, 32'h0, "compare b reset");
    rdchk(OFF_FORCE, 32'h0, "force reads zero");
    chk(compare_pin[0].o, 1'h1, "port data on pin");
    chk(irq_req, 3'h0, "no request");
    $display("reset test done");
  endtask

  task t_compare;
    wr(OFF_CMPA, 32'h1200, 4'h2);
    wr(OFF_CMPA, 32'h0034, 4'h1);
    rdchk(OFF_CMPA, 32'h1234, "paired write");
    wr(OFF_CMPA, 32'h0000, 4'h2);
    wr(OFF_CMPA, 32'h0020, 4'h1);
    wr(OFF_IEN, 32'h2, 4'hf);
    cw(16'h0020);
    tk(1);
    rdchk(OFF_STAT, 32'h0, "match after write");
    cw(16'h001f);
    tk(2);
    rdchk(OFF_STAT, 32'h2, "flag a");
    chk(irq_req, 3'h2, "irq a");
    chk(compare_pin[0].o, 1'h1, "mode off keeps port");
    @(posedge clk);
    irq_ack <= 3'h2;
    @(posedge clk);
    irq_ack <= 3'h0;
    rdchk(OFF_STAT, 32'h0, "serviced clears");
    wr(OFF_CTRL, 32'h100, 4'hf);
    @(posedge clk);
    chk(compare_pin[0].o, 1'h0, "state untouched");
    chk(compare_pin[0].oe, 1'h1, "direction a");
    chk(compare_pin[1].oe, 1'h0, "direction b");
    wr(OFF_FORCE, 32'h1, 4'hf);
    @(posedge clk);
    chk(compare_pin[0].o, 1'h1, "forced toggle");
    rdchk(OFF_STAT, 32'h0, "force no flag");
    cw(16'h001f);
    tk(2);
    chk(compare_pin[0].o, 1'h0, "match toggle");
    rdchk(OFF_STAT, 32'h2, "flag again");
    wr(OFF_STAT, 32'h2, 4'hf);
    rdchk(OFF_STAT, 32'h0, "write one clears");
    wr(OFF_CTRL, 32'h120, 4'hf);
    @(posedge clk);
    chk(top_value, 32'h0020, "compare a as top");
    chk(compare_pin[0].o, 1'h0, "state across mode");
    cw(16'h0020);
    chk(top_match, 1'h0, "top match blocked");
    cw(16'h001f);
    tk(1);
    chk(top_match, 1'h1, "top match");
    $display("compare test done");
  endtask

  task t_buffer;
    wr(OFF_CTRL, 32'h028, 4'hf);
    wr(OFF_CMPA, 32'h0000, 4'h2);
    wr(OFF_CMPA, 32'h0040, 4'h1);
    wr(OFF_STAT, 32'h7, 4'hf);
    cw(16'h001f);
    tk(2);
    rdchk(OFF_STAT, 32'h2, "old value compared");
    rdchk(OFF_CMPA, 32'h0040, "buffer read");
    $display("buffer test done");
  endtask

  task t_capture;
    wr(OFF_CTRL, 32'h104, 4'hf);
    wr(OFF_IEN, 32'h1, 4'hf);
    wr(OFF_STAT, 32'h7, 4'hf);
    cw(16'h1234);
    lat(1'h0, n0);
    rdchk(OFF_CAPT, 32'h1234, "pin capture");
    wr(OFF_CTRL, 32'h106, 4'hf);
    repeat (10) @(posedge clk);
    wr(OFF_STAT, 32'h1, 4'hf);
    capture_pin <= 1'h1;
    repeat (3) @(posedge clk);
    capture_pin <= 1'h0;
    repeat (12) @(posedge clk);
    chk(irq_req[0], 1'h0, "short pulse");
    lat(1'h0, n1);
    chk(n1, n0 + 4, "filter delay");
    cw(16'h5678);
    wr(OFF_CTRL, 32'h107, 4'hf);
    wr(OFF_STAT, 32'h1, 4'hf);
    lat(1'h1, n1);
    rdchk(OFF_CAPT, 32'h5678, "comparator overwrite");
    wr(OFF_CTRL, 32'h064, 4'hf);
    wr(OFF_STAT, 32'h1, 4'hf);
    capture_pin <= 1'h1;
    repeat (12) @(posedge clk);
    chk(irq_req[0], 1'h0, "frozen in capture top");
    $display("capture test done");
  endtask

  initial begin
    #(25 * 20000);
    fails++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    t_compare;
    t_buffer;
    t_capture;
    conclude();
  end
endmodule
